// >>> rtl/pcx_pkg.sv
// Package with register map, field positions, signal table and state type.
package pcx_pkg;
    localparam int NPIN = 32;
    localparam int NSIG = 30;

    // Register indices on the plain register port.
    localparam logic [7:0] PCX_IDX_DATA0  = 8'h00;
    localparam logic [7:0] PCX_IDX_DATA1  = 8'h01;
    localparam logic [7:0] PCX_IDX_DATA2  = 8'h02;
    localparam logic [7:0] PCX_IDX_DATA3  = 8'h03;
    localparam logic [7:0] PCX_IDX_OMODE0 = 8'h04;
    localparam logic [7:0] PCX_IDX_OMODE3 = 8'h07;
    localparam logic [7:0] PCX_IDX_INMODE = 8'h08;
    localparam logic [7:0] PCX_IDX_CFG0   = 8'h09;
    localparam logic [7:0] PCX_IDX_CFG1   = 8'h0a;
    localparam logic [7:0] PCX_IDX_CFG2   = 8'h0b;
    localparam logic [7:0] PCX_IDX_CLAIM0 = 8'h0c;
    localparam logic [7:0] PCX_IDX_CLAIM1 = 8'h0d;
    localparam logic [7:0] PCX_IDX_CLAIM3 = 8'h0f;
    // Address bit 7 selects single-bit access to the port data latches.
    localparam int PCX_BIT_SEL = 7;

    // Field positions in the crossbar configuration registers.
    localparam int CFG0_SMB   = 0;
    localparam int CFG0_SPI   = 1;
    localparam int CFG0_SER0  = 2;
    localparam int CFG0_CEX_L = 3;
    localparam int CFG0_ECI   = 6;
    localparam int CFG0_CP0   = 7;
    localparam int CFG1_CP1   = 0;
    localparam int CFG1_T0    = 1;
    localparam int CFG1_INT0  = 2;
    localparam int CFG1_T1    = 3;
    localparam int CFG1_INT1  = 4;
    localparam int CFG1_T2    = 5;
    localparam int CFG1_T2EX  = 6;
    localparam int CFG1_SYSCK = 7;
    localparam int CFG2_CNV0  = 0;
    localparam int CFG2_CNV2  = 1;
    localparam int CFG2_SER1  = 2;
    localparam int CFG2_T4    = 3;
    localparam int CFG2_XBEN  = 4;
    localparam int CFG2_EXTM  = 5;
    localparam int CFG2_T4EX  = 6;
    localparam int CFG2_PUDIS = 7;

    // Reset values.
    localparam logic [7:0] DATA_RST   = 8'hff;
    localparam logic [7:0] OMODE_RST  = 8'h00;
    localparam logic [7:0] INMODE_RST = 8'hff;

    // Peripheral signal indices in priority order.
    localparam logic [4:0] SIG_TX0  = 5'h00;
    localparam logic [4:0] SIG_RX0  = 5'h01;
    localparam logic [4:0] SIG_CEX0 = 5'h0a;
    localparam logic [4:0] SIG_ECI  = 5'h10;
    localparam logic [4:0] SIG_RX1  = 5'h09;
    localparam logic [4:0] SIG_LAST = 5'h1d;
    // Signals that only ever feed a peripheral.
    localparam logic [29:0] SIG_INPUT_ONLY = 30'h37f9_0000;
    // Two-wire bus data and clock, always open-drain.
    localparam logic [29:0] SIG_TWO_WIRE   = 30'h0000_00c0;

    // Pins that the low-port memory reservation takes away, and the port 1 base pin.
    localparam int PIN_WR  = 7;
    localparam int PIN_RD  = 6;
    localparam int PIN_ALE = 5;
    localparam int PORT1_BASE = 8;

    typedef struct packed {
        logic [31:0]      sync1;
        logic [31:0]      sync2;
        logic [31:0]      latch;
        logic [31:0]      omode;
        logic [7:0]       inmode;
        logic [7:0]       cfg0;
        logic [7:0]       cfg1;
        logic [7:0]       cfg2;
        logic [31:0]      alloc_vld;
        logic [31:0][4:0] alloc_idx;
        logic [31:0]      pin_out;
        logic [31:0]      pin_oe;
        logic [31:0]      pin_pu;
        logic [29:0]      periph_in;
        logic [7:0]       rdata;
    } pcx_state_t;

    localparam pcx_state_t PCX_ST_RST = '{
        latch:   {4{DATA_RST}},
        omode:   {4{OMODE_RST}},
        inmode:  INMODE_RST,
        periph_in: {30{1'b1}},
        default: '0
    };
endpackage

// >>> rtl/pcx_crossbar.sv
// Priority pin crossbar and port 0-3 general-purpose I/O logic.
//
// Notes on behaviour
// - Pins are handed out from port 0 bit 0 upward, only as far as needed.
// - Peripheral signals take pins in fixed priority, serial port 0 first.
// - A peripheral reaches pins only while its enable bits are 1.
// - Serial port 0 enable puts transmit on P0.0 and receive on P0.1.
// - An enabled serial peripheral always gets all of its signals.
// - Unclaimed pins are GPIO driven by byte- and bit-accessible latches.
// - Claimed pins follow their peripheral; latch writes do not move them.
// - A normal port read returns the synchronised pin level.
// - The read phase of read-modify-write returns the data latch instead.
// - All port drivers stay off until the crossbar global enable is 1.
// - Pins carrying peripheral inputs keep their driver off, except during a low-port memory move.
// - Push-pull drives the data bit value both ways.
// - Open-drain drives low for 0 and floats for 1.
// - Output-mode bit 1 is push-pull, 0 open-drain; reset is open-drain.
// - Output-mode bits apply to claimed and GPIO pins alike.
// - Two-wire pins and mode-0 serial receive pins are always open-drain.
// - Weak pullups on after reset, off globally by config 2 bit 7.
// - A pin driving low has its own weak pullup switched off.
// - A port 1 analog input pin has its weak pullup off.
// - Memory interface works on low or upper ports, only during a move.
// - Low-port reservation skips write, read and, multiplexed, latch pins.
// - A port 1 analog pin reads as 0 and is skipped by allocation.
// - Low-port off-chip moves override pin state; reads drop data drivers.
//
// Chosen here: the strobed register port and the register offsets.

`timescale 1ns/1ps

module pcx_crossbar
    import pcx_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_rmw,
    output logic      [7:0]  reg_rdata,
    // Peripheral side.
    input  wire logic [29:0] periph_out,
    input  wire logic [29:0] periph_oe,
    output logic      [29:0] periph_in,
    input  wire logic        ser0_mode0,
    input  wire logic        ser1_mode0,
    // External memory interface.
    input  wire logic        external_memory_interface_active,
    input  wire logic        external_memory_interface_low_sel,
    input  wire logic        external_memory_interface_muxed,
    input  wire logic [31:0] external_memory_interface_out,
    input  wire logic [31:0] external_memory_interface_oe,
    // Pins.
    input  wire logic [31:0] pin_in,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe,
    output logic      [31:0] pin_pullup
);

    pcx_state_t st_reg;
    pcx_state_t st_next;
    logic [31:0] in_pin_mask;

    // Enable decode of one peripheral signal from the config registers.
    function automatic logic sig_en(input logic [4:0] k,
                                    input logic [7:0] c0,
                                    input logic [7:0] c1,
                                    input logic [7:0] c2);
        logic r;
        r = 1'b0;
        // A serial peripheral is a single enable, so all its pins go together.
        if (k <= SIG_RX0) begin
            r = c0[CFG0_SER0];
        end else if (k <= 5'h05) begin
            r = c0[CFG0_SPI];
        end else if (k <= 5'h07) begin
            r = c0[CFG0_SMB];
        end else if (k <= SIG_RX1) begin
            r = c2[CFG2_SER1];
        end else if (k < SIG_ECI) begin
            r = {2'b00, c0[5:CFG0_CEX_L]} > (k - SIG_CEX0);
        end else begin
            case (k)
                5'h10: r = c0[CFG0_ECI];
                5'h11: r = c0[CFG0_CP0];
                5'h12: r = c1[CFG1_CP1];
                5'h13: r = c1[CFG1_T0];
                5'h14: r = c1[CFG1_INT0];
                5'h15: r = c1[CFG1_T1];
                5'h16: r = c1[CFG1_INT1];
                5'h17: r = c1[CFG1_T2];
                5'h18: r = c1[CFG1_T2EX];
                5'h19: r = c2[CFG2_T4];
                5'h1a: r = c2[CFG2_T4EX];
                5'h1b: r = c1[CFG1_SYSCK];
                5'h1c: r = c2[CFG2_CNV0];
                5'h1d: r = c2[CFG2_CNV2];
                default: r = 1'b0;
            endcase
        end
        return r;
    endfunction

    // Analog mask over all 32 pins from the port 1 input-mode byte.
    function automatic logic [31:0] analog_mask(input logic [7:0] im);
        return {16'h0000, ~im, 8'h00};
    endfunction

    // Register, allocation and pin next-state logic.
    always_comb begin
        logic [5:0]  nxt;
        logic        skip;
        logic        found;
        logic [4:0]  idx;
        logic [4:0]  k5;
        logic        val;
        logic        want;
        logic        force_od;
        logic        pp;
        logic [31:0] ana;
        logic [31:0] view;
        logic [7:0]  rd_byte;
        nxt = 6'h00;
        skip = 1'b0;
        found = 1'b0;
        idx = 5'h00;
        k5 = 5'h00;
        val = 1'b0;
        want = 1'b0;
        force_od = 1'b0;
        pp = 1'b0;
        rd_byte = 8'h00;
        st_next = st_reg;
        in_pin_mask = 32'h0;
        ana = analog_mask(st_reg.inmode);

        // Two-stage synchroniser on the pins before anything reads them.
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;

        // Reads see the pin level, or the latch in read-modify-write.
        view = reg_rmw ? st_reg.latch : (st_reg.sync2 & ~ana);
        if (reg_rmw) begin
            view = st_reg.latch;
        end else begin
            view = st_reg.sync2 & ~ana;
        end
        if (reg_addr[PCX_BIT_SEL]) begin
            if (reg_addr[6:5] == 2'b00) begin
                rd_byte = {7'h00, view[reg_addr[4:0]]};
            end
        end else if (reg_addr <= PCX_IDX_DATA3) begin
            rd_byte = view[reg_addr[1:0]*8 +: 8];
        end else if (reg_addr <= PCX_IDX_OMODE3) begin
            rd_byte = st_reg.omode[reg_addr[1:0]*8 +: 8];
        end else if (reg_addr == PCX_IDX_INMODE) begin
            rd_byte = st_reg.inmode;
        end else if (reg_addr == PCX_IDX_CFG0) begin
            rd_byte = st_reg.cfg0;
        end else if (reg_addr == PCX_IDX_CFG1) begin
            rd_byte = st_reg.cfg1;
        end else if (reg_addr == PCX_IDX_CFG2) begin
            rd_byte = st_reg.cfg2;
        end else if (reg_addr <= PCX_IDX_CLAIM3) begin
            rd_byte = st_reg.alloc_vld[reg_addr[1:0]*8 +: 8];
        end
        // Read data stand only in the cycle after the strobe.
        st_next.rdata = reg_rd ? rd_byte : 8'h00;

        // Writes; the latch always stores, claimed pins simply ignore it.
        if (reg_wr) begin
            if (reg_addr[PCX_BIT_SEL]) begin
                if (reg_addr[6:5] == 2'b00) begin
                    st_next.latch[reg_addr[4:0]] = reg_wdata[0];
                end
            end else if (reg_addr <= PCX_IDX_DATA3) begin
                st_next.latch[reg_addr[1:0]*8 +: 8] = reg_wdata;
            end else if (reg_addr <= PCX_IDX_OMODE3) begin
                st_next.omode[reg_addr[1:0]*8 +: 8] = reg_wdata;
            end else if (reg_addr == PCX_IDX_INMODE) begin
                st_next.inmode = reg_wdata;
            end else if (reg_addr == PCX_IDX_CFG0) begin
                st_next.cfg0 = reg_wdata;
            end else if (reg_addr == PCX_IDX_CFG1) begin
                st_next.cfg1 = reg_wdata;
            end else if (reg_addr == PCX_IDX_CFG2) begin
                st_next.cfg2 = reg_wdata;
            end
        end

        // Allocation walks pins upward and hands each the next enabled
        // signal; the nested scan is wide but keeps priority obvious.
        for (int p = 0; p < NPIN; p++) begin
            skip = (st_reg.cfg2[CFG2_EXTM] &&
                    (p == PIN_WR || p == PIN_RD ||
                     (p == PIN_ALE && external_memory_interface_muxed))) ||
                   ana[p];
            found = 1'b0;
            idx = 5'h00;
            if (!skip) begin
                for (int k = 0; k < NSIG; k++) begin
                    k5 = 5'(k);
                    if (!found && {1'b0, k5} >= nxt &&
                        sig_en(k5, st_reg.cfg0, st_reg.cfg1, st_reg.cfg2)) begin
                        found = 1'b1;
                        idx = k5;
                    end
                end
            end
            if (found) begin
                nxt = {1'b0, idx} + 6'h01;
            end
            st_next.alloc_vld[p] = found;
            st_next.alloc_idx[p] = idx;
        end

        // Pin drive from the memory interface, a peripheral or the latch.
        for (int p = 0; p < NPIN; p++) begin
            idx = st_reg.alloc_idx[p];
            force_od = 1'b0;
            if (external_memory_interface_active && external_memory_interface_low_sel) begin
                val = external_memory_interface_out[p];
                want = external_memory_interface_oe[p];
            end else if (st_reg.alloc_vld[p]) begin
                val = periph_out[idx];
                want = periph_oe[idx] && !SIG_INPUT_ONLY[idx];
                in_pin_mask[p] = SIG_INPUT_ONLY[idx];
                force_od = SIG_TWO_WIRE[idx] ||
                           (idx == SIG_RX0 && ser0_mode0) ||
                           (idx == SIG_RX1 && ser1_mode0);
            end else begin
                val = st_reg.latch[p];
                want = 1'b1;
            end
            pp = st_reg.omode[p] && !force_od;
            // Open-drain only ever pulls low; push-pull drives both levels.
            st_next.pin_oe[p] = st_reg.cfg2[CFG2_XBEN] && want &&
                                (pp || !val);
            st_next.pin_out[p] = val;
            st_next.pin_pu[p] = !st_reg.cfg2[CFG2_PUDIS] &&
                                !(st_next.pin_oe[p] && !val) &&
                                !ana[p];
        end

        // Route pin levels to peripheral inputs; idle high when unmapped.
        st_next.periph_in = {30{1'b1}};
        for (int p = 0; p < NPIN; p++) begin
            if (st_reg.alloc_vld[p]) begin
                st_next.periph_in[st_reg.alloc_idx[p]] = st_reg.sync2[p];
            end
        end
    end

    // Single state register; reset leaves everything disabled.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= PCX_ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops.
    assign reg_rdata  = st_reg.rdata;
    assign periph_in  = st_reg.periph_in;
    assign pin_out    = st_reg.pin_out;
    assign pin_oe     = st_reg.pin_oe;
    assign pin_pullup = st_reg.pin_pu;

    // Checks on the registered pin and read behaviour.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_drivers_gated: assert property (
        !st_reg.cfg2[CFG2_XBEN] |=> pin_oe == 32'h0)
        else $error("Driver on while crossbar disabled.");
    a_serial0_place: assert property (
        st_reg.cfg0[CFG0_SER0] |=> st_reg.alloc_vld[1:0] == 2'b11 &&
        st_reg.alloc_idx[0] == SIG_TX0 && st_reg.alloc_idx[1] == SIG_RX0)
        else $error("Serial port 0 not on pins 0 and 1.");
    a_input_undriven: assert property (
        1'b1 |=> (pin_oe & $past(in_pin_mask)) == 32'h0)
        else $error("Driver on a peripheral input pin.");
    a_open_drain_hi: assert property (
        1'b1 |=> (pin_oe & pin_out & ~$past(st_reg.omode)) == 32'h0)
        else $error("Open-drain pin driven high.");
    a_pullup_low_off: assert property (
        (pin_oe & ~pin_out & pin_pullup) == 32'h0)
        else $error("Pullup on while pin drives low.");
    a_pullup_global: assert property (
        st_reg.cfg2[CFG2_PUDIS] |=> pin_pullup == 32'h0)
        else $error("Pullup on while globally disabled.");
    a_rmw_read_latch: assert property (
        reg_rd && reg_rmw && reg_addr == PCX_IDX_DATA0
        |=> reg_rdata == $past(st_reg.latch[7:0]))
        else $error("Read-modify-write did not return latch.");
    a_read_pin_level: assert property (
        reg_rd && !reg_rmw && reg_addr == PCX_IDX_DATA2
        |=> reg_rdata == $past(st_reg.sync2[23:16]))
        else $error("Port read did not return pin level.");
    a_analog_reads_0: assert property (
        reg_rd && !reg_rmw && reg_addr == PCX_IDX_DATA1
        |=> (reg_rdata & ~$past(st_reg.inmode)) == 8'h00)
        else $error("Analog pin read as nonzero.");

    c_serial0_live: cover property (
        st_reg.cfg0[CFG0_SER0] && st_reg.cfg2[CFG2_XBEN] ##1 pin_oe[0]);
    c_rmw_read: cover property (reg_rd && reg_rmw);
    c_external_memory_interface_move: cover property (external_memory_interface_active && external_memory_interface_low_sel);
    c_reserved_skip: cover property (
        st_reg.cfg2[CFG2_EXTM] && st_reg.alloc_vld[8]);

endmodule

// >>> test/pcx_far_end.sv
// Far-side model: the board wires behind the pins, with external drivers.
`timescale 1ns/1ps

module pcx_far_end (
    // Clock.
    input  wire logic        ref_clk,
    // Design pin side.
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pullup,
    output logic      [31:0] pin_in,
    // Board drivers set by the bench.
    input  wire logic [31:0] ext_oe,
    input  wire logic [31:0] ext_val
);
    logic [31:0] float_pat = 32'h0000_0000;

    // A floating wire changes every cycle, so a stale level never passes.
    always_ff @(posedge ref_clk) begin
        float_pat <= ~float_pat;
    end

    // Wire level: device driver first, then the board, then the pullup.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_pat[i];
            end
        end
    end
endmodule

// >>> test/tb_priority_crossbar_port_io.sv
// Testbench for the pin crossbar and port logic.
`timescale 1ns/1ps

module tb_priority_crossbar_port_io;
    import pcx_pkg::*;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        reg_rmw = 1'b0;
    logic [7:0]  reg_rdata;
    logic [29:0] periph_out = '0;
    logic [29:0] periph_oe = '0;
    logic [29:0] periph_in;
    logic        ser0_mode0 = 1'b0;
    logic        external_memory_interface_active = 1'b0;
    logic        external_memory_interface_low_sel = 1'b0;
    logic        external_memory_interface_muxed = 1'b0;
    logic [31:0] external_memory_interface_out = '0;
    logic [31:0] external_memory_interface_oe = '0;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pin_pullup;
    logic [31:0] ext_oe = '0;
    logic [31:0] ext_val = '0;
    int          err_total = 0;
    int          checked = 0;

    // Clock at 50 MHz.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    pcx_crossbar DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rmw(reg_rmw), .reg_rdata(reg_rdata),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .ser0_mode0(ser0_mode0),
        .ser1_mode0(1'b0), .external_memory_interface_active(external_memory_interface_active),
        .external_memory_interface_low_sel(external_memory_interface_low_sel), .external_memory_interface_muxed(external_memory_interface_muxed),
        .external_memory_interface_out(external_memory_interface_out), .external_memory_interface_oe(external_memory_interface_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup)
    );

    pcx_far_end FAR (
        .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_in(pin_in),
        .ext_oe(ext_oe), .ext_val(ext_val)
    );

    // Count a comparison and report a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; data stand only in the following cycle.
    task automatic rdc(input logic [7:0] a, input logic m,
                       input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rmw <= m;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_rmw <= 1'b0;
        #1;
        chk(nm, {24'h0, e}, {24'h0, reg_rdata});
    endtask

    // Let allocation, pin registers and the input synchronisers settle.
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hung run counts as a mismatch.
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        // Reset state: nothing driven, pullups on, open-drain, no claims.
        chk("oe", 32'h0, pin_oe);
        chk("pullup", 32'hffff_ffff, pin_pullup);
        rdc(PCX_IDX_OMODE0, 1'b0, 8'h00, "omode0");
        rdc(PCX_IDX_CFG2, 1'b0, 8'h00, "cfg2");
        rdc(PCX_IDX_CLAIM0, 1'b0, 8'h00, "claim0");
        rdc(PCX_IDX_INMODE, 1'b0, 8'hff, "inmode");
        $display("test reset done");

        // Pin level against latch value, byte and bit access.
        ext_oe <= 32'h00ff_0000;
        ext_val <= 32'h00a5_0000;
        wr(PCX_IDX_DATA2, 8'h5a);
        settle();
        rdc(PCX_IDX_DATA2, 1'b0, 8'ha5, "p2 pins");
        rdc(PCX_IDX_DATA2, 1'b1, 8'h5a, "p2 latch");
        rdc(8'h91, 1'b0, 8'h00, "p2.1 pin");
        rdc(8'h91, 1'b1, 8'h01, "p2.1 latch");
        wr(8'h91, 8'h00);
        rdc(PCX_IDX_DATA2, 1'b1, 8'h58, "p2 bit wr");
        ext_oe <= 32'h0;
        $display("test read paths done");

        // Drivers stay off until the global enable is set.
        wr(PCX_IDX_DATA0, 8'h00);
        wr(PCX_IDX_OMODE0, 8'hff);
        settle();
        chk("oe p0 off", 32'h00, {24'h0, pin_oe[7:0]});
        wr(PCX_IDX_CFG2, 8'h10);
        settle();
        chk("oe p0 pp", 32'hff, {24'h0, pin_oe[7:0]});
        chk("out p0", 32'h00, {24'h0, pin_out[7:0]});
        chk("pu p0 low", 32'h00, {24'h0, pin_pullup[7:0]});
        wr(PCX_IDX_DATA0, 8'h0f);
        settle();
        chk("out p0 hi", 32'h0f, {24'h0, pin_out[7:0]});
        wr(PCX_IDX_OMODE0, 8'h00);
        settle();
        chk("oe p0 od", 32'hf0, {24'h0, pin_oe[7:0]});
        chk("pu p0 od", 32'h0f, {24'h0, pin_pullup[7:0]});
        $display("test output modes done");

        // Serial port 0 on the first two pins; its receive pin is input.
        wr(PCX_IDX_OMODE0, 8'hff);
        periph_oe <= 30'h0000_0003;
        periph_out <= 30'h0000_0002;
        ser0_mode0 <= 1'b1;
        wr(PCX_IDX_CFG0, 8'h04);
        settle();
        rdc(PCX_IDX_CLAIM0, 1'b0, 8'h03, "claim ser0");
        chk("oe p0 ser0", 32'h01, {30'h0, pin_oe[1:0]});
        chk("tx0 pin", 32'h0, {31'h0, pin_out[0]});
        ext_oe <= 32'h0000_0002;
        ext_val <= 32'h0;
        settle();
        chk("rx0 in", 32'h0, {31'h0, periph_in[SIG_RX0]});
        rdc(PCX_IDX_DATA0, 1'b0, 8'h0c, "p0 claimed");
        ext_oe <= 32'h0;
        $display("test serial0 done");

        // Priority order with skipped and reserved pins.
        periph_oe <= 30'h0000_00c0;
        periph_out <= 30'h0000_0040;
        wr(PCX_IDX_CFG0, 8'h05);
        wr(PCX_IDX_CFG2, 8'h14);
        settle();
        rdc(PCX_IDX_CLAIM0, 1'b0, 8'h3f, "claim order");
        chk("oe two wire", 32'h2, {30'h0, pin_oe[3:2]});
        chk("scl low", 32'h0, {31'h0, pin_out[3]});
        external_memory_interface_muxed <= 1'b1;
        wr(PCX_IDX_INMODE, 8'hfe);
        wr(PCX_IDX_CFG2, 8'h34);
        settle();
        rdc(PCX_IDX_CLAIM0, 1'b0, 8'h1f, "claim rsv p0");
        rdc(PCX_IDX_CLAIM1, 1'b0, 8'h02, "claim rsv p1");
        chk("pu analog", 32'h0, {31'h0, pin_pullup[PORT1_BASE]});
        rdc(PCX_IDX_DATA1, 1'b0, 8'hfe, "p1 analog");
        wr(PCX_IDX_CFG0, 8'h00);
        wr(PCX_IDX_CFG2, 8'h10);
        settle();
        rdc(PCX_IDX_CLAIM0, 1'b0, 8'h00, "claim none");
        $display("test priority done");

        // Memory interface override on port 2, then a read cycle.
        wr(PCX_IDX_DATA2, 8'h00);
        wr(8'h06, 8'hff);
        external_memory_interface_low_sel <= 1'b1;
        external_memory_interface_oe <= 32'h00ff_0000;
        external_memory_interface_out <= 32'h003c_0000;
        external_memory_interface_active <= 1'b1;
        settle();
        chk("external_memory_interface out", 32'h3c, {24'h0, pin_out[23:16]});
        chk("external_memory_interface oe", 32'hff, {24'h0, pin_oe[23:16]});
        external_memory_interface_oe <= 32'h0;
        settle();
        chk("external_memory_interface rd oe", 32'h00, {24'h0, pin_oe[23:16]});
        external_memory_interface_active <= 1'b0;
        settle();
        chk("external_memory_interface off", 32'hff, {24'h0, pin_oe[23:16]});
        $display("test memory override done");

        // Global pullup disable.
        wr(PCX_IDX_CFG2, 8'h90);
        settle();
        chk("pu off", 32'h0, pin_pullup);
        $display("test pullup done");
        finish_test();
    end
endmodule
